// ==== verilog/display_pkg.sv ====
// Behaviour
// - Window flag set confines RAM accesses to the min/max X and Y rectangle.
// - Primary direction and X/Y step direction still apply in window mode.
// - Writing starts at whatever X and Y addresses the host has loaded.
// - Burst flag selects ordinary or burst writes; burst words go to staging first.
// - Burst mode commits staging to RAM once four 16-bit words are held.
// - Staging keeps accepting words while the previous group is being written.
// - Fewer than four staged words are kept and later words appended.
// - Chip select dropped then data port written again clears staging.
// - Burst path writes four times the pixels per RAM cycle of ordinary path.
// - X primary: X steps to 83h or 00h, wraps, then Y steps.
// - Y primary: Y steps to AFh or 00h, wraps, then X steps.
// - Primary flag 0 is X, 1 is Y; direction flag 0 increments, 1 decrements.
package display_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_X = 8'h04;
  localparam logic [7:0] OFS_Y = 8'h08;
  localparam logic [7:0] OFS_XMIN = 8'h0C;
  localparam logic [7:0] OFS_XMAX = 8'h10;
  localparam logic [7:0] OFS_YMIN = 8'h14;
  localparam logic [7:0] OFS_YMAX = 8'h18;
  localparam logic [7:0] OFS_DATA = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTRL_W = 5;
  localparam int BIT_WINDOW = 0;
  localparam int BIT_PRIMARY_Y = 1;
  localparam int BIT_XDEC = 2;
  localparam int BIT_YDEC = 3;
  localparam int BIT_BURST = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  // ****************************************
  // Address space and data
  // ****************************************
  localparam int AW = 8;
  localparam logic [AW-1:0] X_FIRST = 8'h00;
  localparam logic [AW-1:0] X_LAST = 8'h83;
  localparam logic [AW-1:0] Y_FIRST = 8'h00;
  localparam logic [AW-1:0] Y_LAST = 8'hAF;
  localparam int PIX_W = 16;
  localparam int BURST_WORDS = 4;
  localparam int GROUP_W = PIX_W * BURST_WORDS;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = PIX_W + 1;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int RAM_WRITE_NS = 160;
  localparam int RAM_WRITE_CYC_I = (RAM_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W = 3;
  localparam logic [BUSY_W-1:0] RAM_WRITE_CYC = BUSY_W'(RAM_WRITE_CYC_I);
endpackage : display_pkg

// ==== verilog/stream_if.sv ====
`timescale 1ns/100ps
interface stream_if #(parameter int W = 17) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : stream_if

// ==== verilog/pixel_fifo.sv ====
`timescale 1ns/100ps
module pixel_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [W-1:0] nxt_mem [DEPTH];
  logic [PW:0] wptr_ff;
  logic [PW:0] rptr_ff;
  logic [PW:0] nxt_wptr;
  logic [PW:0] nxt_rptr;
  logic full;
  logic empty;
  // ****************************************
  // Flags and next state
  // ****************************************
  assign full = (wptr_ff[PW-1:0] == rptr_ff[PW-1:0]) && (wptr_ff[PW] != rptr_ff[PW]);
  assign empty = (wptr_ff == rptr_ff);
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem_ff[rptr_ff[PW-1:0]];
  always_comb begin
    nxt_mem = mem_ff;
    nxt_wptr = wptr_ff;
    nxt_rptr = rptr_ff;
    if (in_s.valid && !full) begin
      nxt_mem[wptr_ff[PW-1:0]] = in_s.data;
      nxt_wptr = wptr_ff + 1'b1;
    end
    if (out_s.ready && !empty) begin
      nxt_rptr = rptr_ff + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      mem_ff <= nxt_mem;
    end
  end
endmodule : pixel_fifo

// ==== verilog/display_write_ctrl.sv ====
`timescale 1ns/100ps
module display_write_ctrl import display_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic host_cs_n,
  output logic ram_we,
  output logic ram_wide,
  output logic [AW-1:0] ram_x,
  output logic [AW-1:0] ram_y,
  output logic [GROUP_W-1:0] ram_data
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [AW-1:0] lane0(input logic [AW-1:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    lane0 = sel[0] ? d[AW-1:0] : old;
  endfunction : lane0

  // Returns {wrapped, next} for one step inside lo..hi
  function automatic logic [AW:0] step(input logic [AW-1:0] v, input logic [AW-1:0] lo,
                                       input logic [AW-1:0] hi, input logic dec);
    if (!dec) begin
      step = (v >= hi) ? {1'b1, lo} : {1'b0, AW'(v + 1'b1)};
    end else begin
      step = (v <= lo) ? {1'b1, hi} : {1'b0, AW'(v - 1'b1)};
    end
  endfunction : step

  // ****************************************
  // State
  // ****************************************
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [AW-1:0] xmin_ff, nxt_xmin;
  logic [AW-1:0] xmax_ff, nxt_xmax;
  logic [AW-1:0] ymin_ff, nxt_ymin;
  logic [AW-1:0] ymax_ff, nxt_ymax;
  logic [AW-1:0] cur_x_ff, nxt_cur_x;
  logic [AW-1:0] cur_y_ff, nxt_cur_y;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic restart_ff, nxt_restart;
  logic [CNT_W-1:0] stg_cnt_ff, nxt_stg_cnt;
  logic [GROUP_W-1:0] stg_data_ff, nxt_stg_data;
  logic [AW-1:0] stg_x_ff, nxt_stg_x;
  logic [AW-1:0] stg_y_ff, nxt_stg_y;
  logic cb_valid_ff, nxt_cb_valid;
  logic cb_wide_ff, nxt_cb_wide;
  logic [GROUP_W-1:0] cb_data_ff, nxt_cb_data;
  logic [AW-1:0] cb_x_ff, nxt_cb_x;
  logic [AW-1:0] cb_y_ff, nxt_cb_y;
  logic [BUSY_W-1:0] busy_ff, nxt_busy;
  logic ram_we_ff, nxt_ram_we;
  logic ram_wide_ff, nxt_ram_wide;
  logic [AW-1:0] ram_x_ff, nxt_ram_x;
  logic [AW-1:0] ram_y_ff, nxt_ram_y;
  logic [GROUP_W-1:0] ram_data_ff, nxt_ram_data;

  logic req, wr_go, data_wr, burst, word_take, cb_take, cb_free, stg_move, first_word;
  logic [AW-1:0] xlo, xhi, ylo, yhi;
  logic [AW:0] sx, sy;
  logic [CNT_W-1:0] base_cnt;
  logic [PIX_W-1:0] word;

  stream_if #(.W(FIFO_W)) push_s ();
  stream_if #(.W(FIFO_W)) pop_s ();

  pixel_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_s(push_s),
    .out_s(pop_s)
  );

  // ****************************************
  // Bus slave
  // ****************************************
  assign req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign data_wr = req && wb_we_i && (wb_adr_i == OFS_DATA) && (wb_sel_i[1:0] == 2'b11)
                   && !host_cs_n;
  assign push_s.valid = data_wr;
  assign push_s.data = {restart_ff, wb_dat_i[PIX_W-1:0]};
  assign wr_go = req && wb_we_i && !host_cs_n && nxt_ack;

  always_comb begin
    nxt_ack = req && (!data_wr || push_s.ready);
    nxt_dat = '0;
    nxt_ctrl = ctrl_ff;
    nxt_xmin = xmin_ff;
    nxt_xmax = xmax_ff;
    nxt_ymin = ymin_ff;
    nxt_ymax = ymax_ff;
    nxt_restart = restart_ff;
    if (host_cs_n) begin
      nxt_restart = 1'b1;
    end else if (data_wr && push_s.ready) begin
      nxt_restart = 1'b0;
    end
    if (wr_go) begin
      case (wb_adr_i)
        OFS_CTRL: nxt_ctrl = wb_sel_i[0] ? wb_dat_i[CTRL_W-1:0] : ctrl_ff;
        OFS_XMIN: nxt_xmin = lane0(xmin_ff, wb_dat_i, wb_sel_i);
        OFS_XMAX: nxt_xmax = lane0(xmax_ff, wb_dat_i, wb_sel_i);
        OFS_YMIN: nxt_ymin = lane0(ymin_ff, wb_dat_i, wb_sel_i);
        OFS_YMAX: nxt_ymax = lane0(ymax_ff, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_CTRL: nxt_dat = 32'(ctrl_ff);
        OFS_X: nxt_dat = 32'(cur_x_ff);
        OFS_Y: nxt_dat = 32'(cur_y_ff);
        OFS_XMIN: nxt_dat = 32'(xmin_ff);
        OFS_XMAX: nxt_dat = 32'(xmax_ff);
        OFS_YMIN: nxt_dat = 32'(ymin_ff);
        OFS_YMAX: nxt_dat = 32'(ymax_ff);
        OFS_STATUS: nxt_dat = 32'({restart_ff, (busy_ff != '0), cb_valid_ff, stg_cnt_ff});
        default: nxt_dat = '0;
      endcase
    end
  end

  // ****************************************
  // Address stepping
  // ****************************************
  assign burst = ctrl_ff[BIT_BURST];
  assign xlo = ctrl_ff[BIT_WINDOW] ? xmin_ff : X_FIRST;
  assign xhi = ctrl_ff[BIT_WINDOW] ? xmax_ff : X_LAST;
  assign ylo = ctrl_ff[BIT_WINDOW] ? ymin_ff : Y_FIRST;
  assign yhi = ctrl_ff[BIT_WINDOW] ? ymax_ff : Y_LAST;
  assign sx = step(cur_x_ff, xlo, xhi, ctrl_ff[BIT_XDEC]);
  assign sy = step(cur_y_ff, ylo, yhi, ctrl_ff[BIT_YDEC]);

  always_comb begin
    nxt_cur_x = cur_x_ff;
    nxt_cur_y = cur_y_ff;
    if (word_take) begin
      if (!ctrl_ff[BIT_PRIMARY_Y]) begin
        nxt_cur_x = sx[AW-1:0];
        nxt_cur_y = sx[AW] ? sy[AW-1:0] : cur_y_ff;
      end else begin
        nxt_cur_y = sy[AW-1:0];
        nxt_cur_x = sy[AW] ? sx[AW-1:0] : cur_x_ff;
      end
    end
    if (wr_go && wb_adr_i == OFS_X) begin
      nxt_cur_x = lane0(cur_x_ff, wb_dat_i, wb_sel_i);
    end
    if (wr_go && wb_adr_i == OFS_Y) begin
      nxt_cur_y = lane0(cur_y_ff, wb_dat_i, wb_sel_i);
    end
  end

  // ****************************************
  // Staging and commit buffer
  // ****************************************
  assign cb_take = cb_valid_ff && (busy_ff == '0);
  assign cb_free = !cb_valid_ff || cb_take;
  assign stg_move = (stg_cnt_ff == CNT_FULL) && cb_free;
  assign pop_s.ready = burst ? (stg_cnt_ff != CNT_FULL) : (cb_free && !stg_move);
  assign word_take = pop_s.valid && pop_s.ready;
  assign word = pop_s.data[PIX_W-1:0];
  assign base_cnt = pop_s.data[PIX_W] ? '0 : stg_cnt_ff;
  assign first_word = (base_cnt == '0);

  always_comb begin
    nxt_stg_cnt = stg_cnt_ff;
    nxt_stg_data = stg_data_ff;
    nxt_stg_x = stg_x_ff;
    nxt_stg_y = stg_y_ff;
    nxt_cb_valid = cb_valid_ff && !cb_take;
    nxt_cb_wide = cb_wide_ff;
    nxt_cb_data = cb_data_ff;
    nxt_cb_x = cb_x_ff;
    nxt_cb_y = cb_y_ff;
    if (stg_move) begin
      nxt_cb_valid = 1'b1;
      nxt_cb_wide = 1'b1;
      nxt_cb_data = stg_data_ff;
      nxt_cb_x = stg_x_ff;
      nxt_cb_y = stg_y_ff;
      nxt_stg_cnt = '0;
    end
    if (word_take && burst) begin
      if (first_word) begin
        nxt_stg_data = '0;
        nxt_stg_x = cur_x_ff;
        nxt_stg_y = cur_y_ff;
      end
      nxt_stg_data[base_cnt[1:0]*PIX_W +: PIX_W] = word;
      nxt_stg_cnt = CNT_W'(base_cnt + 1'b1);
    end else if (word_take) begin
      if (pop_s.data[PIX_W]) begin
        nxt_stg_cnt = '0;
      end
      nxt_cb_valid = 1'b1;
      nxt_cb_wide = 1'b0;
      nxt_cb_data = GROUP_W'(word);
      nxt_cb_x = cur_x_ff;
      nxt_cb_y = cur_y_ff;
    end
  end

  // ****************************************
  // RAM writer
  // ****************************************
  always_comb begin
    nxt_busy = (busy_ff != '0) ? BUSY_W'(busy_ff - 1'b1) : busy_ff;
    nxt_ram_we = 1'b0;
    nxt_ram_wide = ram_wide_ff;
    nxt_ram_x = ram_x_ff;
    nxt_ram_y = ram_y_ff;
    nxt_ram_data = ram_data_ff;
    if (cb_take) begin
      nxt_busy = BUSY_W'(RAM_WRITE_CYC - 1'b1);
      nxt_ram_we = 1'b1;
      nxt_ram_wide = cb_wide_ff;
      nxt_ram_x = cb_x_ff;
      nxt_ram_y = cb_y_ff;
      nxt_ram_data = cb_data_ff;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= CTRL_RST;
      xmin_ff <= X_FIRST;
      xmax_ff <= X_LAST;
      ymin_ff <= Y_FIRST;
      ymax_ff <= Y_LAST;
      cur_x_ff <= X_FIRST;
      cur_y_ff <= Y_FIRST;
      ack_ff <= 1'b0;
      dat_ff <= '0;
      restart_ff <= 1'b0;
      stg_cnt_ff <= '0;
      stg_data_ff <= '0;
      stg_x_ff <= X_FIRST;
      stg_y_ff <= Y_FIRST;
      cb_valid_ff <= 1'b0;
      cb_wide_ff <= 1'b0;
      cb_data_ff <= '0;
      cb_x_ff <= X_FIRST;
      cb_y_ff <= Y_FIRST;
      busy_ff <= '0;
      ram_we_ff <= 1'b0;
      ram_wide_ff <= 1'b0;
      ram_x_ff <= X_FIRST;
      ram_y_ff <= Y_FIRST;
      ram_data_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      xmin_ff <= nxt_xmin;
      xmax_ff <= nxt_xmax;
      ymin_ff <= nxt_ymin;
      ymax_ff <= nxt_ymax;
      cur_x_ff <= nxt_cur_x;
      cur_y_ff <= nxt_cur_y;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      restart_ff <= nxt_restart;
      stg_cnt_ff <= nxt_stg_cnt;
      stg_data_ff <= nxt_stg_data;
      stg_x_ff <= nxt_stg_x;
      stg_y_ff <= nxt_stg_y;
      cb_valid_ff <= nxt_cb_valid;
      cb_wide_ff <= nxt_cb_wide;
      cb_data_ff <= nxt_cb_data;
      cb_x_ff <= nxt_cb_x;
      cb_y_ff <= nxt_cb_y;
      busy_ff <= nxt_busy;
      ram_we_ff <= nxt_ram_we;
      ram_wide_ff <= nxt_ram_wide;
      ram_x_ff <= nxt_ram_x;
      ram_y_ff <= nxt_ram_y;
      ram_data_ff <= nxt_ram_data;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign ram_we = ram_we_ff;
  assign ram_wide = ram_wide_ff;
  assign ram_x = ram_x_ff;
  assign ram_y = ram_y_ff;
  assign ram_data = ram_data_ff;
endmodule : display_write_ctrl

// ==== tb/host_cpu_model.sv ====
`timescale 1ns/100ps
module host_cpu_model (
  input wire logic clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  output logic cs_n,
  input wire logic ack,
  input wire logic [31:0] rdat
);
  int timeouts = 0;
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
    cs_n = 1'b0;
  end
  // Classic cycle, held until ack or timed out after 100 more clocks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (ack !== 1'b1) timeouts++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic set_cs(input logic v);
    cs_n <= v;
    @(posedge clk);
  endtask : set_cs
endmodule : host_cpu_model

// ==== tb/display_write_checker.sv ====
`timescale 1ns/100ps
module display_write_checker import display_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic host_cs_n,
  input wire logic ram_we,
  input wire logic ram_wide,
  input wire logic [AW-1:0] ram_x,
  input wire logic [AW-1:0] ram_y,
  input wire logic [GROUP_W-1:0] ram_data
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_reg_lat;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i != OFS_DATA |=> wb_ack_o;
  endproperty
  a_reg_lat: assert property (p_reg_lat) else $error("register ack late");
  property p_data_lat;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == OFS_DATA && !wb_ack_o |-> ##[1:60] wb_ack_o;
  endproperty
  a_data_lat: assert property (p_data_lat) else $error("pixel write stalled");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_data_rd;
    wb_ack_o && $past(!wb_we_i && wb_adr_i == OFS_DATA) |-> wb_dat_o == 32'h0;
  endproperty
  a_data_rd: assert property (p_data_rd) else $error("data port read not zero");
  property p_spacing;
    ram_we |=> !ram_we [*3];
  endproperty
  a_spacing: assert property (p_spacing) else $error("commits too close");
  property p_range;
    ram_we |-> ram_x <= X_LAST && ram_y <= Y_LAST;
  endproperty
  a_range: assert property (p_range) else $error("commit address out of range");
  c_wide: cover property (ram_we && ram_wide);
  c_narrow: cover property (ram_we && !ram_wide);
  c_pixel: cover property (wb_ack_o && wb_we_i && wb_adr_i == OFS_DATA);
endmodule : display_write_checker
bind display_write_ctrl display_write_checker chk_u (
  .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .host_cs_n(host_cs_n), .ram_we(ram_we), .ram_wide(ram_wide),
  .ram_x(ram_x), .ram_y(ram_y), .ram_data(ram_data)
);

// ==== tb/display_ram_window_burst_write_test.sv ====
`timescale 1ns/100ps
module display_ram_window_burst_write_test import display_pkg::*; ;
  typedef struct {bit w; int x; int y; logic [63:0] d;} exp_t;
  localparam logic [7:0] RA[9] = '{OFS_CTRL, OFS_X, OFS_Y, OFS_XMIN, OFS_XMAX, OFS_YMIN,
    OFS_YMAX, OFS_DATA, 8'h40};
  localparam int RV[9] = '{0, 0, 0, 0, 8'h83, 0, 8'hAF, 0, 0};
  localparam int FULL[4] = '{0, 8'h83, 0, 8'hAF};
  logic clk, rstn, cyc, stb, we, cs_n, ack, ram_we, ram_wide;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat;
  logic [AW-1:0] ram_x, ram_y;
  logic [GROUP_W-1:0] ram_data;
  int bad_count = 0;
  int n_checks = 0;
  int mx, my, gx, gy, bnd[4], sq[$];
  exp_t eq[$];
  logic [4:0] ctrl;
  bit rpend;
  display_write_ctrl dut_u (
    .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .host_cs_n(cs_n),
    .ram_we(ram_we), .ram_wide(ram_wide), .ram_x(ram_x), .ram_y(ram_y), .ram_data(ram_data)
  );
  host_cpu_model host_u (
    .clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat), .cs_n(cs_n),
    .ack(ack), .rdat(rdat)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    host_u.bus(w, a, d, q);
    if (host_u.timeouts != 0) begin
      bad_count++;
      stop_test();
    end
  endtask : xfer
  function automatic int lim(input int i);
    return ctrl[0] ? bnd[i] : FULL[i];
  endfunction : lim
  function automatic int stp(input int v, input int lo, input int hi, input bit dec);
    if (dec) return (v == lo) ? hi : v - 1;
    return (v == hi) ? lo : v + 1;
  endfunction : stp
  function automatic void adv();
    bit w;
    if (!ctrl[1]) begin
      w = mx == (ctrl[2] ? lim(0) : lim(1));
      mx = stp(mx, lim(0), lim(1), ctrl[2]);
      if (w) my = stp(my, lim(2), lim(3), ctrl[3]);
    end else begin
      w = my == (ctrl[3] ? lim(2) : lim(3));
      my = stp(my, lim(2), lim(3), ctrl[3]);
      if (w) mx = stp(mx, lim(0), lim(1), ctrl[2]);
    end
  endfunction : adv
  task automatic wr(input logic [7:0] a, input int d);
    logic [31:0] q;
    xfer(1'b1, a, 32'(d), q);
    case (a)
      OFS_CTRL: ctrl = 5'(d);
      OFS_X: mx = d;
      OFS_Y: my = d;
      OFS_XMIN: bnd[0] = d;
      OFS_XMAX: bnd[1] = d;
      OFS_YMIN: bnd[2] = d;
      OFS_YMAX: bnd[3] = d;
      default: ;
    endcase
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input int e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(64'(q), 64'(e), "register read");
  endtask : rd_chk
  task automatic pix(input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, OFS_DATA, {16'h0000, d}, q);
    if (cs_n !== 1'b0) return;
    if (rpend) sq.delete();
    rpend = 0;
    if (!ctrl[4]) eq.push_back('{1'b0, mx, my, 64'(d)});
    else begin
      if (sq.size() == 0) {gx, gy} = {mx, my};
      sq.push_back(d);
      if (sq.size() == 4) begin
        eq.push_back('{1'b1, gx, gy, {16'(sq[3]), 16'(sq[2]), 16'(sq[1]), 16'(sq[0])}});
        sq.delete();
      end
    end
    adv();
  endtask : pix
  task automatic cs(input logic v);
    host_u.set_cs(v);
    if (v) rpend = 1;
  endtask : cs
  task automatic settle();
    for (int n = 0; n < 400 && eq.size() != 0; n++) @(posedge clk);
    check(64'(eq.size()), 64'h0, "pending commits");
    if (eq.size() != 0) stop_test();
  endtask : settle
  task automatic staged(input int k);
    logic [31:0] q;
    for (int n = 0; n < 50; n++) begin
      xfer(1'b0, OFS_STATUS, 32'h0, q);
      if (q[2:0] == 3'(k)) break;
    end
    check(64'(q[2:0]), 64'(k), "staged count");
    if (q[2:0] != 3'(k)) stop_test();
  endtask : staged
  always @(posedge clk) begin
    exp_t e;
    if (rstn === 1'b1 && ram_we === 1'b1) begin
      if (eq.size() == 0) check(64'h1, 64'h0, "unexpected commit");
      else begin
        e = eq.pop_front();
        check({ram_wide, ram_x, ram_y}, {e.w, 8'(e.x), 8'(e.y)}, "commit place");
        check(ram_data, e.d, "commit data");
      end
    end
  end
  initial begin
    rstn = 1'b0;
    ctrl = '0;
    {mx, my, rpend} = '0;
    bnd = FULL;
    void'($urandom(97880));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wr(8'h40, 8'h1F);
    for (int i = 0; i < 9; i++) rd_chk(RA[i], RV[i]);
    for (int m = 0; m < 16; m++) begin
      wr(OFS_XMIN, $urandom_range(0, 8'h7F));
      wr(OFS_XMAX, bnd[0] + 3);
      wr(OFS_YMIN, $urandom_range(0, 8'hAC));
      wr(OFS_YMAX, bnd[2] + 2);
      wr(OFS_CTRL, {m[2:0], m[3]});
      wr(OFS_X, ctrl[2] ? lim(0) : lim(1));
      wr(OFS_Y, ctrl[3] ? lim(2) : lim(3));
      repeat (6) pix(16'($urandom));
      settle();
      rd_chk(OFS_X, mx);
      rd_chk(OFS_Y, my);
    end
    wr(OFS_CTRL, 0);
    cs(1'b1);
    pix(16'h5A5A);
    cs(1'b0);
    settle();
    rd_chk(OFS_X, mx);
    wr(OFS_CTRL, 8'h10);
    wr(OFS_X, 3);
    wr(OFS_Y, 1);
    repeat (6) pix(16'($urandom));
    staged(2);
    repeat (2) pix(16'($urandom));
    settle();
    repeat (2) pix(16'($urandom));
    staged(2);
    cs(1'b1);
    cs(1'b0);
    wr(OFS_X, 6);
    wr(OFS_Y, 2);
    repeat (4) pix(16'($urandom));
    settle();
    staged(0);
    wr(OFS_XMIN, 3);
    wr(OFS_XMAX, 9);
    wr(OFS_YMIN, 8'h10);
    wr(OFS_YMAX, 8'h12);
    wr(OFS_CTRL, 8'h1B);
    wr(OFS_X, 9);
    wr(OFS_Y, 8'h10);
    repeat (8) pix(16'($urandom));
    settle();
    rd_chk(OFS_X, mx);
    rd_chk(OFS_Y, my);
    stop_test();
  end
endmodule : display_ram_window_burst_write_test
